// ### rtl/failsafe_break_monitor.sv
// Fail-safe break monitor with AXI4-Lite register slave
// What this block does
// - Halt after protected fetch when fetch guard on
// - Halt after protected area write when enabled
// - Halt after protected register read when enabled
// - Halt after protected register write when enabled
// - Halt on stack overflow, guard off by default
// - Hold configurable stack top, full range
// - Halt on stack underflow, guard off by default
// - Hold configurable stack bottom address
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module failsafe_break_monitor (
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire fsb_pkg::core_evt_t evt_i,
    input  wire logic [7:0]        s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [7:0]        s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic                   halt_o,
    output logic                   irq_o
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    logic [5:0]  ctrl_r,  ctrl_nxt;
    logic [5:0]  stat_r,  stat_nxt;
    logic [5:0]  ien_r,   ien_nxt;
    logic [19:0] sttop_r, sttop_nxt;
    logic [19:0] stbot_r, stbot_nxt;
    logic [5:0]  cause_r, cause_nxt;
    logic        halt_r,  halt_nxt;
    logic        irq_r,   irq_nxt;

    logic        aw_got_r,  aw_got_nxt;
    logic        w_got_r,   w_got_nxt;
    logic [7:0]  awaddr_r,  awaddr_nxt;
    logic [31:0] wdata_r,   wdata_nxt;
    logic [3:0]  wstrb_r,   wstrb_nxt;
    logic        bvalid_r,  bvalid_nxt;
    logic [1:0]  bresp_r,   bresp_nxt;
    logic        rvalid_r,  rvalid_nxt;
    logic [31:0] rdata_r,   rdata_nxt;
    logic [1:0]  rresp_r,   rresp_nxt;
    logic        awready_r, awready_nxt;
    logic        wready_r,  wready_nxt;
    logic        arready_r, arready_nxt;

    logic [5:0]  evt_raw;
    logic [5:0]  hit;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    // -------------------------------------------------------------------
    // Violation detection
    // -------------------------------------------------------------------
    always_comb begin
        evt_raw = '0;
        evt_raw[fsb_pkg::BIT_FETCH] = evt_i.fetch_prot;
        evt_raw[fsb_pkg::BIT_AWR]   = evt_i.awr_prot;
        evt_raw[fsb_pkg::BIT_SRD]   = evt_i.srd_prot;
        evt_raw[fsb_pkg::BIT_SWR]   = evt_i.swr_prot;
        // Stack grows downward: below the bottom limit is overflow
        // A pointer equal to a limit is still inside the stack
        evt_raw[fsb_pkg::BIT_OVF] = evt_i.sp_wr
                                  && (evt_i.sp_val < stbot_r);
        evt_raw[fsb_pkg::BIT_UDF] = evt_i.sp_wr
                                  && (evt_i.sp_val > sttop_r);
        hit = evt_raw & ctrl_r;
    end

    // -------------------------------------------------------------------
    // AXI4-Lite slave and register file
    // -------------------------------------------------------------------
    // Write lands only once both halves are held
    assign wr_go = aw_got_r && w_got_r && !bvalid_r;
    // A new read waits until the last one is answered
    assign rd_go = s_axi_arvalid_i && !rvalid_r;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wstrb_r[i]}};
        end
    end

    // -------------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------------
    // Built from the live address so the answer leaves one edge after AR
    always_comb begin
        rd_word = '0;
        rd_resp = fsb_pkg::RESP_OKAY;
        unique case (s_axi_araddr_i)
            fsb_pkg::OFF_CTRL:  rd_word[5:0]  = ctrl_r;
            fsb_pkg::OFF_STTOP: rd_word[19:0] = sttop_r;
            fsb_pkg::OFF_STBOT: rd_word[19:0] = stbot_r;
            fsb_pkg::OFF_STAT:  rd_word[5:0]  = stat_r;
            fsb_pkg::OFF_IEN:   rd_word[5:0]  = ien_r;
            fsb_pkg::OFF_HALT: begin
                rd_word[0]    = halt_r;
                rd_word[13:8] = cause_r;
            end
            // Clear register is write-only and reads as zero
            fsb_pkg::OFF_CLR:   rd_word = '0;
            default:            rd_resp = fsb_pkg::RESP_SLVERR;
        endcase
    end

    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt  = wdata_r;
        wstrb_nxt  = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        ctrl_nxt   = ctrl_r;
        ien_nxt    = ien_r;
        sttop_nxt  = sttop_r;
        stbot_nxt  = stbot_r;
        stat_nxt   = stat_r;
        cause_nxt  = cause_r;
        halt_nxt   = halt_r;

        if (s_axi_awvalid_i && !aw_got_r) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_got_r) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata_i;
            wstrb_nxt = s_axi_wstrb_i;
        end
        if (bvalid_r && s_axi_bready_i) begin
            bvalid_nxt = 1'b0;
        end

        if (wr_go) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = fsb_pkg::RESP_OKAY;
            unique case (awaddr_r)
                fsb_pkg::OFF_CTRL:
                    ctrl_nxt = (ctrl_r & ~wmask[5:0])
                             | (wdata_r[5:0] & wmask[5:0]);
                fsb_pkg::OFF_STTOP:
                    sttop_nxt = (sttop_r & ~wmask[19:0])
                              | (wdata_r[19:0] & wmask[19:0]);
                fsb_pkg::OFF_STBOT:
                    stbot_nxt = (stbot_r & ~wmask[19:0])
                              | (wdata_r[19:0] & wmask[19:0]);
                fsb_pkg::OFF_CLR:
                    stat_nxt = stat_r & ~(wdata_r[5:0] & wmask[5:0]);
                fsb_pkg::OFF_IEN:
                    ien_nxt = (ien_r & ~wmask[5:0])
                            | (wdata_r[5:0] & wmask[5:0]);
                fsb_pkg::OFF_HALT:
                    // Writing bit 0 as one releases the core
                    if (wmask[0] && wdata_r[0]) begin
                        halt_nxt = 1'b0;
                    end
                fsb_pkg::OFF_STAT:
                    bresp_nxt = fsb_pkg::RESP_SLVERR;
                default:
                    bresp_nxt = fsb_pkg::RESP_SLVERR;
            endcase
        end

        if (rvalid_r && s_axi_rready_i) begin
            rvalid_nxt = 1'b0;
        end
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = rd_resp;
            rdata_nxt  = rd_word;
        end

        // Events set after the clear so a same-cycle event is kept
        stat_nxt = stat_nxt | hit;
        // Halt lands the cycle after the offending access
        if (|hit) begin
            halt_nxt = 1'b1;
            // Cause keeps the first hit; later ones show only in status
            if (!halt_r) begin
                cause_nxt = hit;
            end
        end
    end

    // -------------------------------------------------------------------
    // Interrupt
    // -------------------------------------------------------------------
    // Taken from the next status so the line follows the flag edge
    always_comb begin
        irq_nxt = |(stat_nxt & ien_nxt);
    end

    // -------------------------------------------------------------------
    // Ready flags
    // -------------------------------------------------------------------
    // Registered copies keep every bus output straight off a flop
    always_comb begin
        awready_nxt = !aw_got_nxt;
        wready_nxt  = !w_got_nxt;
        arready_nxt = !rvalid_nxt;
    end

    // -------------------------------------------------------------------
    // Guard state
    // -------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r  <= fsb_pkg::CTRL_RST;
            ien_r   <= fsb_pkg::IEN_RST;
            sttop_r <= fsb_pkg::STTOP_RST;
            stbot_r <= fsb_pkg::STBOT_RST;
            stat_r  <= '0;
            cause_r <= '0;
            halt_r  <= 1'b0;
            irq_r   <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            ien_r   <= ien_nxt;
            sttop_r <= sttop_nxt;
            stbot_r <= stbot_nxt;
            stat_r  <= stat_nxt;
            cause_r <= cause_nxt;
            halt_r  <= halt_nxt;
            irq_r   <= irq_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Bus state
    // -------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= fsb_pkg::RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= fsb_pkg::RESP_OKAY;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            arready_r <= 1'b1;
        end else begin
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            arready_r <= arready_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o  = wready_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign halt_o          = halt_r;
    assign irq_o           = irq_r;

endmodule : failsafe_break_monitor

// ### rtl/fsb_pkg.sv
// Package: register map, field layouts and reset values of the break monitor
package fsb_pkg;

    localparam int ADDR_W = 20;

    // -------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STTOP  = 8'h04;
    localparam logic [7:0] OFF_STBOT  = 8'h08;
    localparam logic [7:0] OFF_STAT   = 8'h0C;
    localparam logic [7:0] OFF_CLR    = 8'h10;
    localparam logic [7:0] OFF_IEN    = 8'h14;
    localparam logic [7:0] OFF_HALT   = 8'h18;

    // -------------------------------------------------------------------
    // Guard bit positions, shared by control, status, clear and enable
    // -------------------------------------------------------------------
    localparam int BIT_FETCH = 0;
    localparam int BIT_AWR   = 1;
    localparam int BIT_SRD   = 2;
    localparam int BIT_SWR   = 3;
    localparam int BIT_OVF   = 4;
    localparam int BIT_UDF   = 5;
    localparam int NGUARD    = 6;

    // Fetch, area write, register read and write on; stack guards off
    localparam logic [5:0] CTRL_RST  = 6'h0F;
    localparam logic [5:0] IEN_RST   = 6'h00;
    localparam logic [19:0] STTOP_RST = 20'hFFFFF;
    localparam logic [19:0] STBOT_RST = 20'h00000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Per-cycle view of the core's bus and stack activity
    typedef struct packed {
        logic fetch_prot;
        logic awr_prot;
        logic srd_prot;
        logic swr_prot;
        logic sp_wr;
        logic [ADDR_W-1:0] sp_val;
    } core_evt_t;

endpackage : fsb_pkg

// ### verif/fsb_props.sv
// Checker: port-level assertions of the break monitor
`timescale 1ns/1ps
module fsb_props (
    input wire logic               mclk_i,
    input wire logic               rst_b_i,
    input wire fsb_pkg::core_evt_t evt_i,
    input wire logic               s_axi_awvalid_i,
    input wire logic               s_axi_awready_o,
    input wire logic               s_axi_wvalid_i,
    input wire logic               s_axi_wready_o,
    input wire logic               s_axi_bvalid_o,
    input wire logic               s_axi_bready_i,
    input wire logic               s_axi_arvalid_i,
    input wire logic               s_axi_arready_o,
    input wire logic               s_axi_rvalid_o,
    input wire logic               s_axi_rready_i,
    input wire logic               halt_o,
    input wire logic               irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    a_halt_cause: assert property ($rose(halt_o) |-> $past(|evt_i[24:20]))
        else $error("halt rose without a core event");
    a_halt_hold: assert property (halt_o && !s_axi_wvalid_i
        && !$past(s_axi_wvalid_i) |=> halt_o) else $error("halt dropped");
    a_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while data pending");
    a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o) else $error("read data withdrawn");
    a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o) else $error("write response withdrawn");
    a_ar_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o) else $error("read not answered");
    a_aw_lock: assert property (s_axi_awvalid_i && s_axi_awready_o
        |=> !s_axi_awready_o) else $error("address ready not dropped");
    a_w_lock: assert property (s_axi_wvalid_i && s_axi_wready_o
        |=> !s_axi_wready_o) else $error("data ready not dropped");
    c_halt: cover property ($rose(halt_o));
    c_irq: cover property ($rose(irq_o));
    c_bresp: cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule : fsb_props
bind failsafe_break_monitor fsb_props fsb_props_inst (.*);

// ### verif/core_model.sv
// Core model: one-cycle bus and stack events, silent while halted
`timescale 1ns/1ps
module core_model (
    input  wire logic          clk_i,
    input  wire logic          halt_i,
    input  wire logic          go_i,
    input  wire logic [2:0]    kind_i,
    input  wire logic [19:0]   sp_i,
    output fsb_pkg::core_evt_t evt_o
);
    always @(posedge clk_i) begin
        evt_o <= '0;
        // Stale pointer value must never look like a fresh one
        evt_o.sp_val <= ~evt_o.sp_val;
        if (go_i && !halt_i) begin
            if (kind_i < 3'h4) evt_o[5'd24 - kind_i] <= 1'b1;
            else begin
                evt_o.sp_wr  <= 1'b1;
                evt_o.sp_val <= sp_i;
            end
        end
    end
endmodule : core_model

// ### verif/tb_failsafe_break_monitor.sv
// Testbench: registers, guards, halt and interrupt of the break monitor
`timescale 1ns/1ps
module tb_failsafe_break_monitor;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, go = 1'b0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0, s_axi_awready_o, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, halt_o, irq_o;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, v;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs;
    logic [2:0]  kind = 3'h0;
    logic [19:0] sp = 20'h0, lim;
    fsb_pkg::core_evt_t evt_i;
    integer miscompares = 0, total_checks = 0, cyc = 0, seed = 98, k, en;
    always #4 mclk_i = ~mclk_i;
    core_model core_model_inst (.clk_i(mclk_i), .halt_i(halt_o),
        .go_i(go), .kind_i(kind), .sp_i(sp), .evt_o(evt_i));
    failsafe_break_monitor failsafe_break_monitor_inst (.*);
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            finish_test;
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        s_axi_awaddr_i <= a; s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1; s_axi_wvalid_i <= 1'b1; s_axi_bready_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        rs = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask : wr
    // Read data is only compared when an OKAY answer is expected
    task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] es);
        @(posedge mclk_i);
        s_axi_araddr_i <= a; s_axi_arvalid_i <= 1'b1; s_axi_rready_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        s_axi_rready_i <= 1'b0;
        chk("rresp", {30'h0, es}, {30'h0, s_axi_rresp_o});
        if (es == 2'h0) chk("rdata", e, s_axi_rdata_o);
    endtask : rchk
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rchk(8'h00, 32'h0F, 2'h0);
        rchk(8'h04, 32'hFFFFF, 2'h0);
        rchk(8'h08, 32'h0, 2'h0);
        rchk(8'h0C, 32'h0, 2'h0);
        rchk(8'h1C, 32'h0, 2'h2);
        wr(8'h0C, 32'h3F);
        chk("status write resp", 32'h2, {30'h0, rs});
        for (en = 0; en < 2; en++) for (k = 0; k < 6; k++) begin
            v = $random(seed);
            wr(8'h00, en ? 32'h3F : 32'h0);
            wr(8'h14, (k % 2) ? 32'h0 : 32'h3F);
            lim = (k == 4) ? (v[19:0] | 20'h1) : {1'b0, v[18:0]};
            wr(8'h04, (k == 5) ? {12'h0, lim} : 32'hFFFFF);
            wr(8'h08, (k == 4) ? {12'h0, lim} : 32'h0);
            rchk((k == 4) ? 8'h08 : 8'h04, (k > 3) ? {12'h0, lim} : 32'hFFFFF,
                 2'h0);
            @(posedge mclk_i);
            kind <= k[2:0];
            sp   <= (k == 4) ? lim - 20'h1 : lim + 20'h1;
            go   <= 1'b1;
            @(posedge mclk_i);
            go <= 1'b0;
            repeat (3) @(posedge mclk_i);
            chk("halt", en, {31'h0, halt_o});
            chk("irq", (en && k % 2 == 0), {31'h0, irq_o});
            rchk(8'h0C, en << k, 2'h0);
            rchk(8'h18, en ? ((1 << k) << 8) | 1 : 0, 2'h0);
            wr(8'h18, 32'h1);
            wr(8'h10, 32'h3F);
            chk("clear write resp", 32'h0, {30'h0, rs});
            repeat (2) @(posedge mclk_i);
            chk("released", 32'h0, {30'h0, halt_o, irq_o});
            $display("test %0d done", en * 6 + k);
        end
        finish_test;
    end
endmodule : tb_failsafe_break_monitor
